// >>> pkg/secp_pkg.sv
package secp_pkg;

	// array geometry, smallest density
	localparam int unsigned ADDR_W = 10;

	// opcode layout; bit 3 is a don't care
	localparam logic [7:0] OPC_MASK      = 8'hF7;
	localparam logic [7:0] OPC_SET_LATCH = 8'h06;
	localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
	localparam logic [7:0] OPC_RD_STAT   = 8'h05;
	localparam logic [7:0] OPC_WR_STAT   = 8'h01;
	localparam logic [7:0] OPC_RD_ARR    = 8'h03;
	localparam logic [7:0] OPC_WR_ARR    = 8'h02;

	// status byte field positions
	localparam int unsigned ST_BUSY  = 0;
	localparam int unsigned ST_LATCH = 1;
	localparam int unsigned ST_BP_LO = 2;
	localparam int unsigned ST_BP_HI = 3;
	localparam int unsigned ST_PPEN  = 7;

	// status byte while an internal write runs, and its unused bits 6:4 otherwise
	localparam logic [7:0] STAT_BUSY_FILL = 8'hFF;
	localparam logic [2:0] STAT_GAP       = 3'h0;

	// nonvolatile protection bits after reset
	localparam logic [1:0] BP_RST   = 2'h0;
	localparam logic       PPEN_RST = 1'b0;

	// lowest protected address per block-protect level
	localparam logic [ADDR_W-1:0] PROT_QTR_BASE  = 10'h300;
	localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 10'h200;

	// self-timed write cycle, longest time rounds down
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned T_WC_MS       = 5;
	localparam int unsigned WC_CYCLES     = T_WC_MS * 1000000 / CLK_PERIOD_NS;

	// decoded instructions
	typedef enum logic [2:0] {
		cmd_invalid           = 3'b000,
		set_write_latch_cmd   = 3'b001,
		clear_write_latch_cmd = 3'b010,
		read_status_cmd       = 3'b011,
		write_status_cmd      = 3'b100,
		read_array_cmd        = 3'b101,
		write_array_cmd       = 3'b110
	} secp_cmd_t;

	// serial link phases
	typedef enum logic [2:0] {
		lnk_opcode = 3'b000,
		lnk_addr   = 3'b001,
		lnk_wdata  = 3'b010,
		lnk_rdata  = 3'b011,
		lnk_status = 3'b100,
		lnk_idle   = 3'b101
	} secp_link_t;

endpackage

// >>> hdl/secp_sync.sv
`timescale 1ns/1ps
module secp_sync #(
	parameter int unsigned WIDTH = 1
) (
	// destination clock
	input  wire logic             clk,
	input  wire logic             rst_n,
	// asynchronous level in, synchronised level out
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// two flops per bit; the first is read by the second only
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_q[i] <= 1'b0;
					q[i]      <= 1'b0;
				end else begin
					meta_q[i] <= d[i];
					q[i]      <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule

// >>> hdl/secp_top.sv
`timescale 1ns/1ps
module secp_top
	import secp_pkg::*;
#(
	parameter int unsigned WC_CYC = WC_CYCLES
) (
	// system clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// serial link pins
	input  wire logic              sck,
	input  wire logic              cs_n,
	input  wire logic              si,
	input  wire logic              hold_n,
	input  wire logic              wp_n,
	output logic                   so_o,
	output logic                   so_oe_n,
	// array read side, clocked by sck
	output logic      [ADDR_W-1:0] arr_rd_addr,
	input  wire logic [7:0]        arr_rd_data,
	// array write side, clocked by clk
	output logic                   arr_wr_stb,
	output logic      [ADDR_W-1:0] arr_wr_addr,
	output logic      [7:0]        arr_wr_data,
	output logic                   busy
);

	localparam int unsigned CW = $clog2(WC_CYC + 1);

	// opcode decode, bit 3 ignored
	function automatic secp_cmd_t opcode_decode(input logic [7:0] b);
		logic [7:0] m;
		m = b & OPC_MASK;
		if (m == OPC_SET_LATCH) begin
			return set_write_latch_cmd;
		end else if (m == OPC_CLR_LATCH) begin
			return clear_write_latch_cmd;
		end else if (m == OPC_RD_STAT) begin
			return read_status_cmd;
		end else if (m == OPC_WR_STAT) begin
			return write_status_cmd;
		end else if (m == OPC_RD_ARR) begin
			return read_array_cmd;
		end else if (m == OPC_WR_ARR) begin
			return write_array_cmd;
		end else begin
			return cmd_invalid;
		end
	endfunction

	// true when an address lies in the block-protected segment
	function automatic logic prot_hit(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
		logic hit;
		hit = 1'b0;
		case (bp)
			2'b01: hit = (a >= PROT_QTR_BASE);
			2'b10: hit = (a >= PROT_HALF_BASE);
			2'b11: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// ---------------- link domain (sck) ----------------

	logic              link_rst_n;
	secp_link_t        lst_q;
	logic [2:0]        bit_q;
	logic [7:0]        sh_q;
	logic [7:0]        sh_d;
	logic              addr_lo_q;
	logic              byte_end_q;
	secp_cmd_t         op_c;
	logic              post_c;
	logic              last_bit_c;
	logic [7:0]        out_src_c;
	// words held across the frame end for the system domain
	secp_cmd_t         cmd_q;
	logic [7:0]        data_q;
	logic [ADDR_W-1:0] addr_q;
	logic              tgl_q;
	// output shifter
	logic [7:0]        tx_q;
	logic              so_q;
	logic              drive_q;
	logic [7:0]        stat_s;
	logic [7:0]        stat_q; // status byte, built in the clk domain

	// deselect restarts the shifter, holds nothing over
	assign link_rst_n = rst_n & ~cs_n;

	// status byte crosses into the link clock, quasi-static
	secp_sync #(
		.WIDTH(8)
	) u_stat_sync (
		.clk  (sck),
		.rst_n(rst_n),
		.d    (stat_q),
		.q    (stat_s)
	);

	// next shift value, decode and hand-over strobe
	always_comb begin
		sh_d       = {sh_q[6:0], si};
		op_c       = opcode_decode(sh_d);
		last_bit_c = hold_n && (bit_q == 3'h7);
		post_c     = 1'b0;
		if (last_bit_c && lst_q == lnk_opcode && !stat_s[ST_BUSY]) begin
			post_c = (op_c == set_write_latch_cmd) || (op_c == clear_write_latch_cmd);
		end
		if (last_bit_c && lst_q == lnk_wdata) begin
			post_c = 1'b1;
		end
		out_src_c = (lst_q == lnk_status) ? stat_s : arr_rd_data;
	end

	// sequence state, sampled on rising sck
	always_ff @(posedge sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			lst_q      <= lnk_opcode;
			bit_q      <= 3'h0;
			sh_q       <= 8'h00;
			addr_lo_q  <= 1'b0;
			byte_end_q <= 1'b0;
		end else if (hold_n && lst_q != lnk_idle) begin
			sh_q       <= sh_d;
			bit_q      <= bit_q + 3'h1;
			byte_end_q <= 1'b0;
			if (bit_q == 3'h7) begin
				case (lst_q)
					lnk_opcode: begin
						if (stat_s[ST_BUSY] && op_c != read_status_cmd) begin
							lst_q <= lnk_idle;
						end else begin
							case (op_c)
								read_status_cmd: begin
									lst_q      <= lnk_status;
									byte_end_q <= 1'b1;
								end
								write_status_cmd: lst_q <= lnk_wdata;
								read_array_cmd:   lst_q <= lnk_addr;
								write_array_cmd:  lst_q <= lnk_addr;
								default:          lst_q <= lnk_idle;
							endcase
						end
					end
					lnk_addr: begin
						addr_lo_q <= 1'b1;
						if (addr_lo_q) begin
							if (cmd_q == read_array_cmd) begin
								lst_q      <= lnk_rdata;
								byte_end_q <= 1'b1;
							end else begin
								lst_q <= lnk_wdata;
							end
						end
					end
					lnk_rdata: byte_end_q <= 1'b1;
					lnk_status: byte_end_q <= 1'b1;
					default: lst_q <= lnk_idle;
				endcase
			end
		end
	end

	// held command words and the hand-over toggle
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q  <= cmd_invalid;
			data_q <= 8'h00;
			addr_q <= '0;
			tgl_q  <= 1'b0;
		end else if (!cs_n) begin
			if (post_c) begin
				tgl_q <= ~tgl_q;
			end
			if (last_bit_c && lst_q == lnk_opcode) begin
				cmd_q <= op_c;
			end
			if (last_bit_c && lst_q == lnk_wdata) begin
				data_q <= sh_d;
			end
			if (last_bit_c && lst_q == lnk_addr) begin
				if (addr_lo_q) begin
					addr_q[7:0] <= sh_d;
				end else begin
					addr_q[ADDR_W-1:8] <= sh_d[ADDR_W-9:0];
				end
			end
			if (last_bit_c && lst_q == lnk_rdata) begin
				addr_q <= addr_q + 1'b1; // sequential read
			end
		end
	end

	// output shifter, changes on falling sck
	always_ff @(negedge sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_q    <= 8'h00;
			so_q    <= 1'b0;
			drive_q <= 1'b0;
		end else if (hold_n) begin
			if (byte_end_q) begin
				tx_q    <= out_src_c;
				so_q    <= out_src_c[7];
				drive_q <= 1'b1;
			end else begin
				tx_q <= {tx_q[6:0], 1'b0};
				so_q <= tx_q[6];
			end
		end
	end

	// pin drive: released when deselected, paused or not sending
	assign so_o        = so_q;
	assign so_oe_n     = ~(drive_q & hold_n & ~cs_n);
	assign arr_rd_addr = addr_q;

	// ---------------- system domain (clk) ----------------

	logic [2:0]    pins_s;
	logic          cs_s;
	logic          wp_s;
	logic          tgl_s;
	logic          cs_prev_q;
	logic          tgl_prev_q;
	logic          frame_end;
	logic          evt_post;
	logic          commit;
	logic          hw_prot;
	logic          wr_go;
	logic          wc_done;
	logic          pend_q;
	logic          abort_q;
	logic          latch_q;
	logic          busy_q;
	logic [CW-1:0] wc_cnt_q;
	logic [1:0]    bp_q;
	logic          ppen_q;
	logic [2:0]    nv_new_q;
	logic          nv_stage_q;

	// chip select, protect pin and the hand-over toggle cross on two flops;
	// pins go in inverted so the reset value matches their idle high level
	secp_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.d    ({~cs_n, ~wp_n, tgl_q}),
		.q    (pins_s)
	);

	assign cs_s  = ~pins_s[2]; // no false frame end after reset
	assign wp_s  = ~pins_s[1];
	assign tgl_s = pins_s[0];

	// edge detectors on the synchronised levels
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_prev_q  <= 1'b1;
			tgl_prev_q <= 1'b0;
		end else begin
			cs_prev_q  <= cs_s;
			tgl_prev_q <= tgl_s;
		end
	end

	assign frame_end = cs_s & ~cs_prev_q;
	assign evt_post  = tgl_s ^ tgl_prev_q;
	assign commit    = frame_end & (pend_q | evt_post) & ~busy_q;
	assign hw_prot   = ~wp_s & ppen_q;
	assign wc_done   = busy_q & (wc_cnt_q == CW'(WC_CYC - 1));

	// a write cycle starts only with the latch set and no protection hit
	assign wr_go = commit & latch_q & (
		(cmd_q == write_status_cmd & ~abort_q & ~hw_prot) |
		(cmd_q == write_array_cmd & ~prot_hit(bp_q, addr_q)));

	// a posted command waits for the frame end; the frame end consumes
	// a post of the same cycle, so nothing is left over for a later frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
		end else if (frame_end) begin
			pend_q <= 1'b0;
		end else if (evt_post) begin
			pend_q <= 1'b1;
		end
	end

	// protect pin low inside the frame, with ppen set, kills a status write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			abort_q <= 1'b0;
		end else if (~cs_s & hw_prot) begin
			abort_q <= 1'b1;
		end else if (frame_end) begin
			abort_q <= 1'b0;
		end
	end

	// write latch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_q <= 1'b0;
		end else if (commit && cmd_q == set_write_latch_cmd) begin
			latch_q <= 1'b1;
		end else if (commit && cmd_q == clear_write_latch_cmd) begin
			latch_q <= 1'b0;
		end else if (wc_done) begin
			latch_q <= 1'b0;
		end
	end

	// self-timed write cycle; once started the protect pin is ignored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q   <= 1'b0;
			wc_cnt_q <= '0;
		end else if (wr_go) begin
			busy_q   <= 1'b1;
			wc_cnt_q <= '0;
		end else if (wc_done) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			wc_cnt_q <= wc_cnt_q + 1'b1;
		end
	end

	// protection bits, applied when their write cycle completes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bp_q       <= BP_RST;
			ppen_q     <= PPEN_RST;
			nv_new_q   <= 3'h0;
			nv_stage_q <= 1'b0;
		end else if (wr_go && cmd_q == write_status_cmd) begin
			nv_new_q   <= {data_q[ST_PPEN], data_q[ST_BP_HI], data_q[ST_BP_LO]};
			nv_stage_q <= 1'b1;
		end else if (wc_done && nv_stage_q) begin
			ppen_q     <= nv_new_q[2];
			bp_q       <= nv_new_q[1:0];
			nv_stage_q <= 1'b0;
		end
	end

	// array write strobe with its address and data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arr_wr_stb  <= 1'b0;
			arr_wr_addr <= '0;
			arr_wr_data <= 8'h00;
		end else begin
			arr_wr_stb <= wr_go && cmd_q == write_array_cmd;
			if (wr_go && cmd_q == write_array_cmd) begin
				arr_wr_addr <= addr_q;
				arr_wr_data <= data_q;
			end
		end
	end

	// status byte as the link reads it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= 8'h00;
		end else if (busy_q) begin
			stat_q <= STAT_BUSY_FILL;
		end else begin
			stat_q <= {ppen_q, STAT_GAP, bp_q, latch_q, 1'b0};
		end
	end

	assign busy = busy_q;

endmodule

// >>> tb/secp_top_assertions.sv
`timescale 1ns/1ps
module secp_top_assertions
	import secp_pkg::*;
#(
	parameter int unsigned WC_CYC = WC_CYCLES
) (
	// clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// link pins
	input wire logic              cs_n,
	input wire logic              hold_n,
	input wire logic              so_oe_n,
	// array write side
	input wire logic              arr_wr_stb,
	input wire logic [ADDR_W-1:0] arr_wr_addr,
	input wire logic [7:0]        arr_wr_data,
	input wire logic              busy
);
	// length of the current busy stretch
	int unsigned bcnt_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			bcnt_q <= 0;
		else
			bcnt_q <= busy ? bcnt_q + 1 : 0;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_desel_so_off: assert property (cs_n |-> so_oe_n)
		else $error("so driven while deselected");
	a_hold_so_off: assert property (!hold_n |-> so_oe_n)
		else $error("so driven while paused");
	a_stb_one_clk: assert property (arr_wr_stb |=> !arr_wr_stb)
		else $error("write strobe wider than one cycle");
	a_stb_starts_busy: assert property (arr_wr_stb |-> $rose(busy))
		else $error("write accepted without busy rising");
	a_busy_no_stb: assert property ($past(busy) |-> !arr_wr_stb)
		else $error("write accepted while busy");
	a_busy_length: assert property ($fell(busy) |->
		bcnt_q >= WC_CYC - 1 && bcnt_q <= WC_CYC + 1)
		else $error("write cycle length wrong");
	a_wr_held_busy: assert property (busy && !arr_wr_stb |->
		$stable(arr_wr_addr) && $stable(arr_wr_data))
		else $error("write address or data moved while busy");
	a_busy_after_desel: assert property ($rose(busy) |-> cs_n)
		else $error("write cycle began inside a frame");

	// main scenarios reached
	cover property (arr_wr_stb);
	cover property ($fell(busy));
	cover property ($fell(so_oe_n));
endmodule

bind secp_top secp_top_assertions #(.WC_CYC(WC_CYC)) u_chk (
	.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .hold_n(hold_n), .so_oe_n(so_oe_n),
	.arr_wr_stb(arr_wr_stb), .arr_wr_addr(arr_wr_addr), .arr_wr_data(arr_wr_data),
	.busy(busy)
);

// >>> tb/secp_spi_master.sv
`timescale 1ns/1ps
module secp_spi_master (
	// link pins driven by the master
	output logic      sck,
	output logic      cs_n,
	output logic      si,
	output logic      hold_n,
	// device output
	input wire logic  so_o,
	input wire logic  so_oe_n
);
	logic idle;      // clock idle level, mode 0 or 3
	logic hold_leak; // so seen driven while paused
	initial begin
		idle = 1'b0;
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		hold_n = 1'b1;
		hold_leak = 1'b0;
	end
	// select with the clock parked at idle
	task automatic sel();
		sck = idle; // master owns the clock
		#30 cs_n = 1'b0; // frame start
		#30;
	endtask
	// park the clock, then deselect; data line keeps changing
	task automatic desel();
		sck = idle;
		#30 cs_n = 1'b1;
		si = ~si;
		#270;
	endtask
	// pause while the clock is low and wiggle it meanwhile
	task automatic pause();
		hold_n = 1'b0; // pause
		repeat (3) begin
			#24 sck = 1'b1;
			if (so_oe_n !== 1'b1)
				hold_leak = 1'b1;
			#24 sck = 1'b0;
		end
		#24 hold_n = 1'b1; // resume
		#24;
	endtask
	// one byte msb first; data set with clock low, taken on rising edge
	task automatic xfer(input logic [7:0] tx, input int hb, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			si = tx[i]; // msb first
			if (i == hb) begin
				si = ~tx[i];
				pause();
				si = tx[i];
			end
			#24 sck = 1'b1;
			rx[i] = so_oe_n ? 1'bx : so_o;
			#24;
		end
	endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench
	import secp_pkg::*;
;
	localparam int WC    = 60;    // shortened write cycle
	localparam int LIMIT = 40000; // run ceiling in clocks
	logic              clk, rst_n, wp_n, sck, cs_n, si, hold_n, so_o, so_oe_n;
	logic              arr_wr_stb, busy;
	logic [ADDR_W-1:0] arr_rd_addr, arr_wr_addr, wa;
	logic [7:0]        arr_rd_data, arr_wr_data, rx, wd;
	int                n_errors, samples_checked, cyc, n_stb, seed, latch, bp, ppen;
	logic [7:0]        bad [4] = '{8'h07, 8'h0F, 8'h85, 8'hFF};
	logic [ADDR_W-1:0] edge_a [4] = '{10'h1FF, 10'h200, 10'h2FF, 10'h300};

	// system clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	secp_top #(.WC_CYC(WC)) uut (
		.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
		.wp_n(wp_n), .so_o(so_o), .so_oe_n(so_oe_n), .arr_rd_addr(arr_rd_addr),
		.arr_rd_data(arr_rd_data), .arr_wr_stb(arr_wr_stb), .arr_wr_addr(arr_wr_addr),
		.arr_wr_data(arr_wr_data), .busy(busy)
	);
	secp_spi_master m (
		.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_o(so_o), .so_oe_n(so_oe_n)
	);

	// array contents as a function of address
	function automatic logic [7:0] mem(input int a);
		return a[7:0] ^ {a[9:8], 6'h15};
	endfunction
	assign arr_rd_data = mem(arr_rd_addr);

	// record accepted array writes
	always @(negedge clk) begin
		if (arr_wr_stb === 1'b1) begin
			n_stb++;
			wa = arr_wr_addr;
			wd = arr_wr_data;
		end
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_errors++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (n_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_wr(input int n0, input logic [9:0] a, input logic [7:0] d, input int ok);
		samples_checked++;
		if (n_stb != n0 + ok || (ok != 0 && (wa !== a || wd !== d))) begin
			n_errors++;
			$display("[FAIL] %0t array write %h %h wrongly handled", $time, a, d);
		end
	endtask
	// one frame of n bytes, last byte optionally paused at bit hb
	task automatic frame(input logic [39:0] b, input int n, input int hb);
		m.sel();
		for (int k = 0; k < n; k++)
			m.xfer(b[39-8*k -: 8], k == n - 1 ? hb : -1, rx);
		m.desel();
		repeat (8) @(negedge clk);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 4 * WC && busy !== 1'b0; i++)
			@(negedge clk);
		chk_byte({7'h0, busy}, 8'h00);
		repeat (8) @(negedge clk);
	endtask
	task automatic rd_stat(input logic [7:0] op, input int hb, input int bsy);
		frame({op, 32'h0}, 2, hb);
		chk_byte(rx, bsy ? 8'hFF : {ppen[0], 3'h0, bp[1:0], latch[0], 1'b0});
	endtask
	task automatic set_latch(input int on);
		frame({on ? 8'h06 : 8'h04, 32'h0}, 1, -1);
		latch = on;
	endtask
	task automatic wr_stat(input logic [7:0] d, input int abort);
		int ok;
		ok = latch && !(ppen && !wp_n) && !abort;
		fork
			frame({8'h01, d, 24'h0}, 2, -1);
			if (abort) begin
				repeat (10) @(negedge clk);
				wp_n = 1'b0;
			end
		join
		chk_byte({7'h0, busy}, 8'(ok));
		if (ok) begin
			rd_stat(8'h05, -1, 1); // all ones
			wait_idle();
			ppen = d[7];
			bp = d[3:2];
			latch = 0;
		end
	endtask
	task automatic wr_arr(input logic [ADDR_W-1:0] a);
		int n0, ok;
		logic [7:0] d;
		n0 = n_stb;
		d = 8'($random(seed));
		ok = latch && !(bp == 3 || bp == 2 && a >= PROT_HALF_BASE || bp == 1 && a >= PROT_QTR_BASE);
		frame({8'h02, 6'h00, a, d, 8'h00}, 4, -1);
		chk_wr(n0, a, d, ok);
		chk_byte({7'h0, busy}, 8'(ok));
		if (ok) begin
			wait_idle();
			latch = 0;
		end
	endtask

	initial begin
		rst_n = 1'b0;
		wp_n = 1'b1;
		seed = 23310;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		for (int md = 0; md < 2; md++) begin
			m.idle = md[0]; // mode 0 then 3
			rd_stat(8'h05, -1, 0);
			rd_stat(8'h0D, 4, 0);
			chk_byte({7'h0, m.hold_leak}, 8'h00);
			foreach (bad[i]) begin
				frame({bad[i], 32'h0}, 3, -1);
				chk_byte(rx, 8'hXX);
			end
			set_latch(1);
			rd_stat(8'h05, -1, 0);
			for (int v = 0; v < 4; v++) begin
				wp_n = 1'($random(seed));
				set_latch(1);
				wr_stat({4'h0, v[1:0], 2'h0}, 0);
				foreach (edge_a[j]) begin
					set_latch(1);
					wr_arr(edge_a[j]);
				end
				wr_arr(10'($random(seed)));
			end
			wp_n = 1'b1;
			set_latch(1);
			wr_stat(8'hF6, 0);
			wp_n = 1'b0;
			set_latch(1);
			wr_stat(8'h00, 0);
			rd_stat(8'h05, -1, 0);
			set_latch(0);
			rd_stat(8'h05, -1, 0);
			set_latch(1);
			wr_arr(10'h000);
			wp_n = 1'b1;
			set_latch(1);
			wr_stat(8'h00, 1);
			rd_stat(8'h05, -1, 0);
			wp_n = 1'b1;
			wr_stat(8'h00, 0);
			rd_arr(10'($random(seed)));
		end
		end_sim();
	end
	task automatic rd_arr(input logic [ADDR_W-1:0] a);
		for (int n = 4; n < 6; n++) begin
			frame({8'h03, 6'h00, a, 16'h0}, n, -1);
			chk_byte(rx, mem(a + n - 4));
		end
	endtask
endmodule
